// ==== hw/sss_pkg.sv ====
// Shared constants and types for the supply state supervisor.
// Assumes a 250 MHz reference clock and asynchronous supply monitors.
package sss_pkg;

    // Reference clock rate
    localparam int CLK_MHZ = 250;

    // Interval after leaving undervoltage, in microseconds
    localparam int FUSE_TIME_US = 50;
    localparam int ACTIVE_MIN_US = 250;
    localparam int ACTIVE_TYP_US = 340;
    localparam int ACTIVE_MAX_US = 450;

    // Cycle counts derived from the rate
    localparam int FUSE_CYC = FUSE_TIME_US * CLK_MHZ;
    localparam int ACTIVE_CYC = ACTIVE_TYP_US * CLK_MHZ;
    localparam int ACTIVE_MIN_CYC = ACTIVE_MIN_US * CLK_MHZ;
    localparam int ACTIVE_MAX_CYC = ACTIVE_MAX_US * CLK_MHZ;

    // Current source setting
    localparam int WET_W = 3;
    localparam logic [WET_W-1:0] WET_LIMIT_CODE = 3'h0;

    // Reset values of the sticky status bits
    localparam logic UV_FLAG_RST = 1'b0;
    localparam logic POR_FLAG_RST = 1'b1;

    // Reset values of the synchronised monitor levels and chip-select
    localparam logic UV_SYNC_RST = 1'b1;
    localparam logic OV_SYNC_RST = 1'b0;
    localparam logic IO_SYNC_RST = 1'b0;
    localparam logic CS_SYNC_RST = 1'b1;

    typedef struct packed {
        logic undervoltage_lockout;
        logic overvoltage;
        logic io_supply_good;
    } sss_monitor_t;

    typedef enum logic [1:0] {
        ST_UV = 2'b00,
        ST_FUSE = 2'b01,
        ST_WAIT = 2'b10,
        ST_NORMAL = 2'b11
    } sss_state_t;

endpackage

// ==== hw/sss_sync.sv ====
// Two-stage level synchroniser for a group of asynchronous inputs.
// Assumes each bit is a slow level; no relation is kept between bits.
`timescale 1ns/10ps
module sss_sync #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            meta_reg <= RST_VAL;
            sync_reg <= RST_VAL;
        end
        else
        begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;
endmodule

// ==== hw/sss_interval_timer.sv ====
// Saturating up-counter that measures time since a clear.
// Assumes the caller compares the count against its own limits.
`timescale 1ns/10ps
module sss_interval_timer #(
    parameter int WIDTH = 20
) (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_clear,
    input wire logic i_run,
    output logic [WIDTH-1:0] o_count
);
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;
    wire at_top = &count_reg;

    assign count_next = i_clear ? '0 :
        (i_run && !at_top) ? count_reg + 1'b1 : count_reg;

    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            count_reg <= '0;
        else
            count_reg <= count_next;
    end

    assign o_count = count_reg;
endmodule

// ==== hw/sss_supervisor.sv ====
// Supply state supervisor: lockout, start-up delay, current limiting
// and serial gating for a switch-detection device.
// Assumes i_reset_n comes from the power-on reset detector and that
// the serial engine and current sources sit outside on this clock.
//
// Behaviour
// - Serial data output is high impedance during undervoltage lockout.
// - Chip-select is ignored during undervoltage lockout.
// - Lockout mid-frame discards the frame and enters lockout.
// - Sticky undervoltage flag, readable once lockout has ended.
// - Comparators and current sources are off during lockout.
// - After power-on reset the state is undervoltage lockout.
// - Power-on reset sets the reset-occurred flag.
// - Reset restores register defaults and disables serial traffic.
// - With I/O supply up, interrupt line held low until ready to operate and talk.
// - Overvoltage limits current sources; settings stay untouched.
// - Overvoltage end restores programmed current settings.
// - I/O supply loss keeps state, only communication stops.
// - I/O supply return resumes communication without reset.
// - Battery before I/O supply: defaults kept, logic outputs undriven.
// - Low battery range: serial works, no false switch states.
// - Double battery range sets no fault and changes nothing.
// - Lockout exit to normal mode takes 250 to 450 us.
// - Fuses are read for about 50 us, then a wait state until normal mode.
`timescale 1ns/10ps
module sss_supervisor #(
    parameter int FUSE_CYC = sss_pkg::FUSE_CYC,
    parameter int ACTIVE_CYC = sss_pkg::ACTIVE_CYC,
    parameter int TMR_W = 20
) (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire sss_pkg::sss_monitor_t i_monitor,
    input wire logic i_cs_n,
    input wire logic i_miso_data,
    input wire logic i_miso_drive,
    input wire logic i_frame_done,
    input wire logic i_int_req,
    input wire logic [sss_pkg::WET_W-1:0] i_wetting_sel,
    input wire logic i_uv_flag_clear,
    input wire logic i_por_flag_clear,
    output logic o_cs_n_gated,
    output logic o_miso_out,
    output logic o_miso_oe,
    output logic o_frame_apply,
    output logic o_frame_discard,
    output logic o_comm_ok,
    output logic o_int_n_out,
    output logic o_int_n_oe,
    output logic o_io_drive_en,
    output logic o_comparator_en,
    output logic o_current_src_en,
    output logic o_current_limit,
    output logic [sss_pkg::WET_W-1:0] o_wetting_sel,
    output logic o_fuse_read_en,
    output logic o_reg_defaults,
    output logic o_uv_flag,
    output logic o_por_flag,
    output sss_pkg::sss_state_t o_state
);
    import sss_pkg::*;

    localparam logic [TMR_W-1:0] FUSE_LAST = TMR_W'(FUSE_CYC - 1);
    localparam logic [TMR_W-1:0] ACTIVE_LAST = TMR_W'(ACTIVE_CYC - 1);
    localparam logic [3:0] SYNC_RST =
        {UV_SYNC_RST, OV_SYNC_RST, IO_SYNC_RST, CS_SYNC_RST};

    sss_state_t state_reg;
    sss_state_t state_next;
    logic [3:0] sync_bus;
    logic [TMR_W-1:0] tmr_count;
    logic uv_prev_reg;
    logic frame_open_reg;
    logic frame_open_next;
    logic uv_flag_reg;
    logic por_flag_reg;
    logic reg_defaults_reg;
    logic int_low_reg;
    logic miso_out_reg;
    logic [WET_W-1:0] wet_reg;

    // Monitor levels and chip-select come from other domains
    sss_sync #(
        .WIDTH(4),
        .RST_VAL(SYNC_RST)
    ) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n),
        .i_async({i_monitor.undervoltage_lockout, i_monitor.overvoltage,
                  i_monitor.io_supply_good, i_cs_n}),
        .o_sync(sync_bus)
    );

    wire uv_sync = sync_bus[3];
    wire ov_sync = sync_bus[2];
    wire io_good = sync_bus[1];
    wire cs_n_sync = sync_bus[0];

    wire in_uv = (state_reg == ST_UV);
    wire in_fuse = (state_reg == ST_FUSE);
    wire in_wait = (state_reg == ST_WAIT);
    wire in_normal = (state_reg == ST_NORMAL);
    wire uv_rise = uv_sync && !uv_prev_reg;

    sss_interval_timer #(
        .WIDTH(TMR_W)
    ) u_timer (
        .i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n),
        .i_clear(in_uv || uv_sync),
        .i_run(in_fuse || in_wait),
        .o_count(tmr_count)
    );

    // Any lockout sends the machine back; the delay restarts from zero
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_UV:
                if (!uv_sync)
                    state_next = ST_FUSE;
            ST_FUSE:
                if (uv_sync)
                    state_next = ST_UV;
                else if (tmr_count == FUSE_LAST)
                    state_next = ST_WAIT;
            ST_WAIT:
                if (uv_sync)
                    state_next = ST_UV;
                else if (tmr_count == ACTIVE_LAST)
                    state_next = ST_NORMAL;
            ST_NORMAL:
                if (uv_sync)
                    state_next = ST_UV;
        endcase
    end

    // Only lockout, the fuse and wait start-up states and the I/O supply gate traffic; low or double
    // battery ranges have no input here and cannot disturb it.
    assign o_comm_ok = in_normal && io_good;
    assign o_cs_n_gated = cs_n_sync || !o_comm_ok;

    // Frame stands while chip-select is low and talking is allowed;
    // it closes with chip-select, so a later lockout finds no stale frame
    assign frame_open_next = !cs_n_sync && o_comm_ok && !uv_sync;
    assign o_frame_discard = frame_open_reg && uv_rise;
    assign o_frame_apply = i_frame_done && frame_open_reg && o_comm_ok
        && !uv_sync;

    // Serial output only drives while fully up and the I/O rail exists
    assign o_miso_oe = i_miso_drive && o_comm_ok;
    assign o_miso_out = miso_out_reg;
    assign o_io_drive_en = io_good;

    // Open-drain interrupt: pulled low while not ready and the I/O rail exists
    assign o_int_n_out = 1'b0;
    assign o_int_n_oe = io_good && int_low_reg;

    assign o_comparator_en = in_normal;
    assign o_current_src_en = in_normal;
    assign o_current_limit = ov_sync;
    assign o_wetting_sel = wet_reg;
    assign o_fuse_read_en = in_fuse;
    assign o_reg_defaults = reg_defaults_reg;
    assign o_uv_flag = uv_flag_reg;
    assign o_por_flag = por_flag_reg;
    assign o_state = state_reg;

    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_reg <= ST_UV;
            uv_prev_reg <= UV_SYNC_RST;
            frame_open_reg <= 1'b0;
            reg_defaults_reg <= 1'b1;
            int_low_reg <= 1'b1;
            miso_out_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            uv_prev_reg <= uv_sync;
            frame_open_reg <= frame_open_next;
            reg_defaults_reg <= 1'b0;
            int_low_reg <= !(o_comm_ok && !i_int_req);
            miso_out_reg <= i_miso_data;
        end
    end

    // The programmed code is never overwritten, so it returns by itself
    // once the overvoltage ends.
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            wet_reg <= WET_LIMIT_CODE;
        else if (ov_sync)
            wet_reg <= WET_LIMIT_CODE;
        else
            wet_reg <= i_wetting_sel;
    end

    // Sticky flags: a new event wins over a clear in the same cycle
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            uv_flag_reg <= UV_FLAG_RST;
            por_flag_reg <= POR_FLAG_RST;
        end
        else
        begin
            if (uv_rise)
                uv_flag_reg <= 1'b1;
            else if (i_uv_flag_clear)
                uv_flag_reg <= 1'b0;
            if (i_por_flag_clear)
                por_flag_reg <= 1'b0;
        end
    end

    // Helper: cycles spent from leaving lockout until normal mode
    logic [TMR_W-1:0] since_uv_reg;
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            since_uv_reg <= '0;
        else if (in_uv)
            since_uv_reg <= '0;
        else if (!in_normal)
            since_uv_reg <= since_uv_reg + 1'b1;
    end

    chk_miso_lockout_hiz: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        in_uv |-> !o_miso_oe)
        else $error("serial output driven during lockout");

    chk_cs_lockout_ignored: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        (in_uv || !io_good) |-> o_cs_n_gated && !frame_open_next)
        else $error("chip-select accepted during lockout");

    chk_cs_normal_pass: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        (o_comm_ok && !cs_n_sync) |-> !o_cs_n_gated)
        else $error("chip-select blocked while talking is allowed");

    chk_frame_discard_uv: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        (frame_open_reg && uv_rise) |-> o_frame_discard && !o_frame_apply
            ##1 (in_uv && !frame_open_reg))
        else $error("frame not discarded on lockout");

    chk_uv_flag_sticky: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        (uv_rise || (o_uv_flag && !i_uv_flag_clear)) |=> o_uv_flag)
        else $error("undervoltage flag not held");

    chk_sources_off_uv: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        !in_normal |-> !o_current_src_en && !o_comparator_en)
        else $error("current sources on outside normal mode");

    chk_int_low_unready: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        (!$past(o_comm_ok) && io_good) |-> o_int_n_oe)
        else $error("interrupt released before ready");

    chk_overvolt_limit: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        ov_sync |=> (o_wetting_sel == WET_LIMIT_CODE) && o_current_limit
            || !ov_sync)
        else $error("current not limited in overvoltage");

    chk_overvolt_restore: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        $fell(ov_sync) && !ov_sync |=>
            o_wetting_sel == $past(i_wetting_sel))
        else $error("current setting not restored");

    chk_io_loss_state: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        (in_normal && !io_good && !uv_sync) |=> in_normal && !o_comm_ok
            || io_good)
        else $error("state changed on I/O supply loss");

    chk_active_time: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        $rose(in_normal) |-> since_uv_reg == TMR_W'(ACTIVE_CYC))
        else $error("active time from lockout exit is wrong");

    chk_fuse_length: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        $rose(in_wait) |-> since_uv_reg == TMR_W'(FUSE_CYC))
        else $error("fuse read interval is wrong");

    chk_start_in_uv: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        $fell(o_reg_defaults) |-> in_uv)
        else $error("did not start in lockout");
endmodule

// ==== dv/sss_mcu_model.sv ====
// Controller model on the far side of the supervisor's serial port.
// Assumes the bench resolves the open-drain interrupt line with a pull-up.
`timescale 1ns/10ps
module sss_mcu_model (
    input wire logic i_ref_clk,
    input wire logic i_int_line,
    output logic o_cs_n
);
    initial
    begin
        o_cs_n = 1'b1;
    end

    // Selects once the interrupt line is released, or after 300 cycles
    task automatic begin_frame(output logic rdy);
        int n;
        n = 0;
        while (i_int_line !== 1'b1 && n < 300)
        begin
            @(negedge i_ref_clk);
            n++;
        end
        rdy = i_int_line;
        @(posedge i_ref_clk);
        o_cs_n <= 1'b0;
    endtask

    // Chip-select stays high long enough for the synchroniser to see it
    task automatic end_frame();
        @(posedge i_ref_clk);
        o_cs_n <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
    endtask

    // Deliberately ignores readiness; used to probe the lockout
    task automatic pulse_cs();
        @(posedge i_ref_clk);
        o_cs_n <= 1'b0;
        repeat (4) @(posedge i_ref_clk);
        o_cs_n <= 1'b1;
    endtask
endmodule

// ==== dv/sss_supervisor_tb.sv ====
// Self-checking bench for the supply state supervisor.
// Assumes short fuse and active counts; the controller model drives select.
`timescale 1ns/10ps
module sss_supervisor_tb;
    import sss_pkg::*;
    localparam int FUSE_T = 5;
    localparam int ACT_T = 20;
    logic clk, rst_n, cs_n, miso_data, miso_drive, frame_done, int_req;
    logic uv_clr, por_clr, cs_gated, miso_out, miso_oe, f_apply, f_discard;
    logic comm_ok, int_out, int_oe, io_en, cmp_en, src_en, cur_lim, fuse_en;
    logic reg_def, uv_flag, por_flag, int_line, rdy;
    logic [WET_W-1:0] wet_sel, wet_out, s;
    sss_monitor_t mon;
    sss_state_t state;
    int failures, checks, seed, k;
    int cyc = 0;

    // Open-drain line with a pull-up
    assign int_line = int_oe ? int_out : 1'b1;

    sss_mcu_model mcu (.i_ref_clk(clk), .i_int_line(int_line), .o_cs_n(cs_n));

    sss_supervisor #(.FUSE_CYC(FUSE_T), .ACTIVE_CYC(ACT_T)) dut (
        .i_ref_clk(clk), .i_reset_n(rst_n), .i_monitor(mon), .i_cs_n(cs_n),
        .i_miso_data(miso_data), .i_miso_drive(miso_drive),
        .i_frame_done(frame_done), .i_int_req(int_req),
        .i_wetting_sel(wet_sel), .i_uv_flag_clear(uv_clr),
        .i_por_flag_clear(por_clr), .o_cs_n_gated(cs_gated),
        .o_miso_out(miso_out), .o_miso_oe(miso_oe), .o_frame_apply(f_apply),
        .o_frame_discard(f_discard), .o_comm_ok(comm_ok),
        .o_int_n_out(int_out), .o_int_n_oe(int_oe), .o_io_drive_en(io_en),
        .o_comparator_en(cmp_en), .o_current_src_en(src_en),
        .o_current_limit(cur_lim), .o_wetting_sel(wet_out),
        .o_fuse_read_en(fuse_en), .o_reg_defaults(reg_def),
        .o_uv_flag(uv_flag), .o_por_flag(por_flag), .o_state(state));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    function automatic logic [WET_W-1:0] exp_wet(logic ov, logic [2:0] sel);
        return ov ? WET_LIMIT_CODE : sel;
    endfunction

    task automatic chk_bit(input logic got, input logic exp, input string m);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH %0t %s got %b exp %b", $time, m, got, exp);
        end
    endtask

    task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp,
                           input string m);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH %0t %s got %0h exp %0h", $time, m, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // A hung wait costs at most this many cycles
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            failures++;
            give_verdict();
        end
    end

    task automatic power_up();
        int n, f;
        n = 0;
        f = 0;
        @(posedge clk);
        mon.undervoltage_lockout <= 1'b0;
        while (state !== ST_NORMAL && n < 1000)
        begin
            @(negedge clk);
            n++;
            if (fuse_en === 1'b1)
                f++;
        end
        // Two synchroniser edges and the state edge come before the first
        // fuse cycle, and the loop counts the launch cycle as well
        chk_vec(16'(n), 16'(ACT_T + 4), "active time");
        chk_vec(16'(f), 16'(FUSE_T), "fuse time");
    endtask

    task automatic do_frame(input logic exp);
        mcu.begin_frame(rdy);
        chk_bit(rdy, 1'b1, "line ready");
        repeat (4) @(posedge clk);
        frame_done <= 1'b1;
        @(negedge clk);
        chk_bit(f_apply, exp, "frame apply");
        chk_bit(cs_gated, ~exp, "cs passed");
        @(posedge clk);
        frame_done <= 1'b0;
        mcu.end_frame();
    endtask

    task automatic settle(input sss_monitor_t m);
        @(posedge clk);
        mon <= m;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask

    initial
    begin
        seed = 19253;
        failures = 0;
        checks = 0;
        rst_n = 1'b0;
        mon = 3'b100;
        {miso_data, miso_drive, frame_done, int_req, uv_clr, por_clr} = '0;
        wet_sel = 3'h5;
        repeat (10) @(posedge clk);
        @(negedge clk);
        chk_vec(16'(state), 16'(ST_UV), "reset state");
        chk_bit(por_flag, 1'b1, "por flag");
        chk_bit(reg_def, 1'b1, "defaults");
        chk_bit(cs_gated, 1'b1, "cs gated");
        @(posedge clk);
        rst_n <= 1'b1;
        miso_drive <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk_bit(reg_def, 1'b0, "defaults off");
        chk_bit(int_oe, 1'b0, "int undriven");
        chk_bit(io_en, 1'b0, "io drive off");
        settle(3'b101);
        chk_bit(int_line, 1'b0, "int held low");
        chk_bit(io_en, 1'b1, "io drive on");
        fork
            mcu.pulse_cs();
            repeat (6)
            begin
                @(negedge clk);
                chk_bit(cs_gated, 1'b1, "cs in lockout");
                chk_bit(miso_oe, 1'b0, "miso in lockout");
                chk_bit(src_en | cmp_en, 1'b0, "sources off");
            end
        join
        power_up();
        chk_bit(comm_ok & cmp_en & src_en, 1'b1, "normal");
        @(negedge clk);
        chk_bit(int_line, 1'b1, "int released");
        do_frame(1'b1);
        // Lockout strikes while a frame is open
        mcu.begin_frame(rdy);
        repeat (4) @(posedge clk);
        mon.undervoltage_lockout <= 1'b1;
        k = 0;
        repeat (6)
        begin
            @(negedge clk);
            k += int'(f_discard === 1'b1);
        end
        chk_vec(16'(k), 16'h1, "discard count");
        chk_vec(16'(state), 16'(ST_UV), "lockout state");
        mcu.end_frame();
        power_up();
        chk_bit(uv_flag, 1'b1, "uv flag kept");
        @(posedge clk);
        {uv_clr, por_clr} <= 2'b11;
        @(posedge clk);
        {uv_clr, por_clr} <= 2'b00;
        @(negedge clk);
        chk_bit(uv_flag | por_flag, 1'b0, "flags cleared");
        s = 3'($random(seed)) | 3'h1;
        @(posedge clk);
        wet_sel <= s;
        settle(3'b011);
        chk_vec(16'(wet_out), 16'(exp_wet(1'b1, s)), "limited");
        chk_bit(cur_lim & comm_ok, 1'b1, "ov normal");
        settle(3'b001);
        chk_vec(16'(wet_out), 16'(exp_wet(1'b0, s)), "restored");
        chk_bit(cur_lim, 1'b0, "limit off");
        settle(3'b000);
        chk_bit(comm_ok, 1'b0, "io lost");
        chk_vec(16'(state), 16'(ST_NORMAL), "state kept");
        do_frame(1'b0);
        settle(3'b001);
        do_frame(1'b1);
        repeat (30)
        begin
            @(posedge clk);
            {wet_sel, miso_data, miso_drive, int_req} <= 6'($random(seed));
            @(posedge clk);
            @(negedge clk);
            s = exp_wet(1'b0, wet_sel);
            chk_vec(16'(wet_out), 16'(s), "wet follow");
            chk_bit(miso_out, miso_data, "miso data");
            chk_bit(miso_oe, miso_drive, "miso drive");
            chk_bit(int_line, ~int_req, "int request");
        end
        @(posedge clk);
        rst_n <= 1'b0;
        @(negedge clk);
        chk_bit(por_flag & ~comm_ok, 1'b1, "second reset");
        chk_vec(16'(state), 16'(ST_UV), "second reset state");
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        chk_bit(reg_def, 1'b0, "defaults off again");
        chk_vec(16'(state), 16'(ST_UV), "restart state");
        give_verdict();
    end
endmodule
